// ### include/smbtc_pkg.sv
package smbtc_pkg;

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CFG_OFFSET = 8'h00;
  localparam logic [7:0]  CTL_OFFSET = 8'h04;
  localparam logic [7:0]  DAT_OFFSET = 8'h08;
  localparam logic [7:0]  CFG_RESET  = 8'h00;
  localparam logic [8:0]  CTL_RESET  = 9'h000;
  localparam logic [7:0]  DAT_RESET  = 8'h00;

  // ----------------------------------------------------------------
  // Bit timing in system clocks and source periods
  // ----------------------------------------------------------------
  localparam logic [3:0]  HOLD_STD   = 4'h3;
  localparam logic [3:0]  HOLD_EXT   = 4'hc;
  localparam logic [3:0]  SETUP_STD  = 4'h1;
  localparam logic [3:0]  SETUP_EXT  = 4'hb;
  localparam logic [1:0]  LOW_TICKS  = 2'h1;
  localparam logic [1:0]  HIGH_TICKS = 2'h2;
  localparam logic [3:0]  FREE_TICKS = 4'ha;
  localparam logic [3:0]  LAST_DATA  = 4'h7;
  localparam logic [3:0]  ACK_SLOT   = 4'h8;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       interfaceEnable;
    logic       slaveInhibit;
    logic       busy;
    logic       sdaHoldExtension;
    logic       sclLowTimeoutEnable;
    logic       busFreeTimeoutEnable;
    logic       clockSourceSelectHi;
    logic       clockSourceSelectLo;
  } smbtc_cfg_t;

  typedef struct packed {
    logic       stopSeen;
    logic       txMode;
    logic       master;
    logic       ackIn;
    logic       hwAck;
    logic       eventFlag;
    logic       ackOut;
    logic       stopReq;
    logic       startReq;
  } smbtc_ctl_t;

  localparam int CTL_W = $bits(smbtc_ctl_t);

  // ----------------------------------------------------------------
  // Master clock generator states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    M_IDLE  = 3'b000,
    M_START = 3'b001,
    M_LOW   = 3'b010,
    M_HIGH  = 3'b011,
    M_STOP  = 3'b100
  } smbtc_mst_t;

endpackage

// ### core/smbtc_core.sv
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
// Functional notes
// [RL1] Slaves may stretch SCL low; master waits for SCL really high.
// [RL2] Low clock beyond 25 ms is a timeout; communication reset within 10 ms.
// [RL3] With timeout enabled, timer reloads while SCL high, counts while low.
// [RL4] Software sets timer to 25 ms and recovers by disable then enable.
// [RL5] Bus free once SCL and SDA high for over 10 source periods.
// [RL6] A pending master START is issued when the free timeout expires.
// [RL7] Software keeps the selected source running, even for slave-only use.
// [RL8] An event is raised for every data byte and address byte.
// [RL9] Without hardware ack: transmit after ACK, receive before ACK.
// [RL10] With hardware ack the byte event always follows the ACK bit.
// [RL11] Events also on master START generated and slave STOP detected.
// [RL12] Interface enable turns on both master and slave handling.
// [RL13] Inhibited slave keeps watching, NACKs addresses, raises no events.
// [RL14] Slave inhibit takes effect from the next START only.
// [RL15] Source select 00 t0, 01 t1, 10 t2 high, 11 t2 low overflow.
// [RL16] Selected source used only for master timing and free timeout.
// [RL17] Master minimum SCL low and high are one source period each.
// [RL18] Unstretched master SCL is two periods high, one low.
// [RL19] Master bit rate never exceeds the minimum high and low limits.
// [RL20] Normal hold at least 3 clocks; setup at least 1 clock plus delay.
// [RL21] Extended timing: setup at least 11 clocks, hold at least 12.
// [RL22] Software delay runs from data or ACK write to flag clear.
// [RL23] Busy set during a transfer, cleared on STOP or free timeout.
// [RL24] Master counts SCL high only after seeing SCL actually high.
module smbtc_core
  import smbtc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Timer overflow pulses
  input  wire logic        timer0Ovf,
  input  wire logic        timer1Ovf,
  input  wire logic        timer2HiOvf,
  input  wire logic        timer2LoOvf,
  // Timeout timer control
  output logic             timer3Reload,
  output logic             timer3Run,
  // Bus pins
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe_n,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe_n,
  // Status
  output logic             eventFlag,
  output logic             busy
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  smbtc_cfg_t  cfg_q;
  smbtc_mst_t  mstSt_q, mstSt_d;
  logic [1:0]  tickCnt_q, tickCnt_d;
  logic        mstScl_q, mstScl_d;
  logic        sdaDrv_q, sdaDrv_d;
  logic        sdaUpd;
  logic        sclPrev_q, sdaPrev_q;
  logic [3:0]  freeCnt_q;
  logic [3:0]  holdCnt_q;
  logic [3:0]  setupCnt_q;
  logic [3:0]  bitPos_q;
  logic        sawRise_q;
  logic        updPend_q;
  logic [7:0]  data_q;
  logic        ackIn_q, txMode_q, addrPhase_q;
  logic        slaveAct_q, inhibAct_q, slvHold_q;
  logic        busy_q, eventFlag_q, stopSeen_q;
  logic        startReq_q, stopReq_q, ackOut_q, hwAck_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q;
  logic        sclOe_n_q, sdaOe_n_q, t3Reload_q, t3Run_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire         apbAcc  = psel & penable;
  wire         apbDone = apbAcc & pready_q;
  wire         hitCfg  = (paddr == CFG_OFFSET);
  wire         hitCtl  = (paddr == CTL_OFFSET);
  wire         hitDat  = (paddr == DAT_OFFSET);
  wire         hitAny  = hitCfg | hitCtl | hitDat;
  wire         wrCfg   = apbDone & pwrite & hitCfg;
  wire         wrCtl   = apbDone & pwrite & hitCtl;
  wire         wrDat   = apbDone & pwrite & hitDat;
  wire smbtc_ctl_t wdCtl = smbtc_ctl_t'(pwdata[CTL_W-1:0]);

  wire smbtc_cfg_t cfgRd = '{
    interfaceEnable:      cfg_q.interfaceEnable,
    slaveInhibit:         cfg_q.slaveInhibit,
    busy:                 busy_q,
    sdaHoldExtension:     cfg_q.sdaHoldExtension,
    sclLowTimeoutEnable:  cfg_q.sclLowTimeoutEnable,
    busFreeTimeoutEnable: cfg_q.busFreeTimeoutEnable,
    clockSourceSelectHi:  cfg_q.clockSourceSelectHi,
    clockSourceSelectLo:  cfg_q.clockSourceSelectLo
  };
  wire smbtc_ctl_t ctlRd = '{
    stopSeen:  stopSeen_q,
    txMode:    txMode_q,
    master:    mstSt_q != M_IDLE,
    ackIn:     ackIn_q,
    hwAck:     hwAck_q,
    eventFlag: eventFlag_q,
    ackOut:    ackOut_q,
    stopReq:   stopReq_q,
    startReq:  startReq_q
  };
  wire [31:0]  rdMux = hitCfg ? 32'(cfgRd) :
                       hitCtl ? 32'(ctlRd) :
                       hitDat ? 32'(data_q) : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Bus observation
  // ----------------------------------------------------------------
  wire         enable    = cfg_q.interfaceEnable;
  wire         sclRise   = sclIn & ~sclPrev_q;
  wire         sclFall   = ~sclIn & sclPrev_q;
  wire         startDet  = sclIn & sclPrev_q & sdaPrev_q & ~sdaIn;
  wire         stopDet   = sclIn & sclPrev_q & ~sdaPrev_q & sdaIn;
  wire         master    = (mstSt_q != M_IDLE);
  wire         inXfer    = master | slaveAct_q;
  wire         fallAdv   = sclFall & sawRise_q & inXfer;

  // ----------------------------------------------------------------
  // Clock source and free timeout
  // ----------------------------------------------------------------
  wire [1:0]   srcSel    = {cfg_q.clockSourceSelectHi, cfg_q.clockSourceSelectLo};
  wire [3:0]   srcVec    = {timer2LoOvf, timer2HiOvf, timer1Ovf, timer0Ovf}; // RL15
  wire         srcUse    = master | startReq_q | cfg_q.busFreeTimeoutEnable;
  wire         srcTick   = srcVec[srcSel] & enable & srcUse; // RL16
  wire         freeHigh  = sclIn & sdaIn & cfg_q.busFreeTimeoutEnable & enable;
  wire         freeExpire = freeHigh & srcTick & (freeCnt_q == FREE_TICKS); // RL5

  // ----------------------------------------------------------------
  // Setup, hold and event decode
  // ----------------------------------------------------------------
  wire [3:0]   holdMin   = cfg_q.sdaHoldExtension ? HOLD_EXT : HOLD_STD; // RL20 RL21
  wire [3:0]   setupMin  = cfg_q.sdaHoldExtension ? SETUP_EXT : SETUP_STD; // RL20 RL21
  wire         holdDone  = (holdCnt_q >= holdMin);
  wire         setupOk   = (setupCnt_q >= setupMin);
  wire         lowDone   = (tickCnt_q >= LOW_TICKS);
  wire         stopWant  = stopReq_q & (bitPos_q == 4'h0) & ~sawRise_q;
  wire         slvEvtOk  = slaveAct_q & ~inhibAct_q; // RL13
  wire         evtOk     = master | slvEvtOk;
  wire         startGo   = (mstSt_q == M_IDLE) & (mstSt_d == M_START);
  wire         startEv   = (mstSt_q == M_START) & srcTick; // RL11
  wire         byteEndEv = fallAdv & (bitPos_q == LAST_DATA) & ~txMode_q & ~hwAck_q
                           & evtOk; // RL9
  wire         ackEndEv  = fallAdv & (bitPos_q == ACK_SLOT) & (txMode_q | hwAck_q)
                           & evtOk; // RL9 RL10
  wire         stopEv    = stopDet & slvEvtOk; // RL11
  wire         eventSet  = startEv | byteEndEv | ackEndEv | stopEv; // RL8
  wire         updGo     = updPend_q & holdDone & ~eventFlag_q & inXfer
                           & ~(master & stopWant); // RL22
  wire [2:0]   bitIdx    = 3'(LAST_DATA[2:0] - bitPos_q[2:0]);
  wire         ackDrive  = (slaveAct_q & inhibAct_q) ? 1'b0 :
                           (hwAck_q ? 1'b1 : ackOut_q); // RL13
  wire         bitVal    = (bitPos_q < ACK_SLOT) ? (txMode_q & ~data_q[bitIdx])
                                                 : (~txMode_q & ackDrive);
  wire         rwBit     = data_q[0];

  // ----------------------------------------------------------------
  // Master SCL generator
  // ----------------------------------------------------------------
  always_comb begin
    mstSt_d   = mstSt_q;
    tickCnt_d = tickCnt_q;
    mstScl_d  = mstScl_q;
    if (!enable) begin
      mstSt_d   = M_IDLE;
      tickCnt_d = 2'h0;
      mstScl_d  = 1'b0;
    end else begin
      case (mstSt_q)
        M_IDLE: begin
          if (startReq_q && !slaveAct_q && (!busy_q || freeExpire)) begin // RL6
            mstSt_d   = M_START;
            tickCnt_d = 2'h0;
          end
        end
        M_START: begin
          if (srcTick) begin
            mstSt_d   = M_LOW;
            mstScl_d  = 1'b1;
            tickCnt_d = 2'h0;
          end
        end
        M_LOW: begin
          if (srcTick && !lowDone) begin
            tickCnt_d = 2'(tickCnt_q + 2'h1); // RL17
          end
          if (stopWant && holdDone && !eventFlag_q) begin
            mstSt_d   = M_STOP;
            tickCnt_d = 2'h0;
          end else if (lowDone && setupOk && !eventFlag_q && !updPend_q) begin // RL19
            mstSt_d   = M_HIGH;
            mstScl_d  = 1'b0;
            tickCnt_d = 2'h0;
          end
        end
        M_HIGH: begin
          if (!sclIn) begin
            if (tickCnt_q != 2'h0) begin // RL1
              mstSt_d   = M_LOW;
              mstScl_d  = 1'b1;
              tickCnt_d = 2'h0;
            end
          end else if (srcTick) begin // RL24
            if (tickCnt_q == 2'(HIGH_TICKS - 2'h1)) begin // RL18
              mstSt_d   = M_LOW;
              mstScl_d  = 1'b1;
              tickCnt_d = 2'h0;
            end else begin
              tickCnt_d = 2'(tickCnt_q + 2'h1);
            end
          end
        end
        M_STOP: begin
          if (mstScl_q) begin
            if (srcTick && setupOk) begin
              mstScl_d = 1'b0;
            end
          end else if (sclIn && srcTick) begin
            mstSt_d = M_IDLE;
          end
        end
        default: begin
          mstSt_d = M_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // SDA drive selection
  // ----------------------------------------------------------------
  always_comb begin
    sdaDrv_d = sdaDrv_q;
    sdaUpd   = 1'b0;
    if (!enable) begin
      sdaDrv_d = 1'b0;
    end else if (startGo) begin
      sdaDrv_d = 1'b1;
      sdaUpd   = 1'b1;
    end else if ((mstSt_q == M_LOW) && (mstSt_d == M_STOP)) begin
      sdaDrv_d = 1'b1;
      sdaUpd   = 1'b1;
    end else if ((mstSt_q == M_STOP) && (mstSt_d == M_IDLE)) begin
      sdaDrv_d = 1'b0;
    end else if (updGo) begin // RL20 RL21
      sdaDrv_d = bitVal;
      sdaUpd   = 1'b1;
    end else if (!inXfer) begin
      sdaDrv_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mstSt_q   <= M_IDLE;
      tickCnt_q <= 2'h0;
      mstScl_q  <= 1'b0;
      sdaDrv_q  <= 1'b0;
    end else if (clkEn) begin
      mstSt_q   <= mstSt_d;
      tickCnt_q <= tickCnt_d;
      mstScl_q  <= mstScl_d;
      sdaDrv_q  <= sdaDrv_d;
    end
  end

  // ----------------------------------------------------------------
  // Timing counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclPrev_q  <= 1'b1;
      sdaPrev_q  <= 1'b1;
      freeCnt_q  <= 4'h0;
      holdCnt_q  <= 4'h0;
      setupCnt_q <= 4'h0;
    end else if (clkEn) begin
      sclPrev_q <= sclIn;
      sdaPrev_q <= sdaIn;
      if (!freeHigh) begin
        freeCnt_q <= 4'h0;
      end else if (srcTick && freeCnt_q <= FREE_TICKS) begin
        freeCnt_q <= 4'(freeCnt_q + 4'h1);
      end
      if (sclFall) begin
        holdCnt_q <= 4'h0;
      end else if (holdCnt_q != 4'hf) begin
        holdCnt_q <= 4'(holdCnt_q + 4'h1);
      end
      if (sdaUpd) begin
        setupCnt_q <= 4'h0;
      end else if (setupCnt_q != 4'hf) begin
        setupCnt_q <= 4'(setupCnt_q + 4'h1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitPos_q    <= 4'h0;
      sawRise_q   <= 1'b0;
      updPend_q   <= 1'b0;
      data_q      <= DAT_RESET;
      ackIn_q     <= 1'b0;
      txMode_q    <= 1'b0;
      addrPhase_q <= 1'b0;
    end else if (clkEn) begin
      if (startDet || startEv) begin
        bitPos_q    <= 4'h0;
        sawRise_q   <= 1'b0;
        addrPhase_q <= 1'b1;
        txMode_q    <= startEv;
      end else if (sclRise && inXfer) begin
        sawRise_q <= 1'b1;
        if (bitPos_q == ACK_SLOT) begin
          ackIn_q <= ~sdaIn;
        end else if (!txMode_q) begin
          data_q <= {data_q[6:0], sdaIn};
        end
      end else if (fallAdv) begin
        sawRise_q <= 1'b0;
        if (bitPos_q == ACK_SLOT) begin
          bitPos_q    <= 4'h0;
          addrPhase_q <= 1'b0;
          if (addrPhase_q) begin
            txMode_q <= master ? ~rwBit : rwBit;
          end
        end else begin
          bitPos_q <= 4'(bitPos_q + 4'h1);
        end
      end else if (wrDat) begin
        data_q <= pwdata[7:0];
      end
      if (!inXfer || updGo) begin
        updPend_q <= 1'b0;
      end else if (sclFall) begin
        updPend_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Slave tracking and busy
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slaveAct_q <= 1'b0;
      inhibAct_q <= 1'b0;
      slvHold_q  <= 1'b0;
      busy_q     <= 1'b0;
    end else if (clkEn) begin
      if (!enable || stopDet || freeExpire) begin // RL2
        slaveAct_q <= 1'b0;
      end else if (startDet && !master) begin // RL12
        slaveAct_q <= 1'b1;
        inhibAct_q <= cfg_q.slaveInhibit; // RL14
      end else if (fallAdv && addrPhase_q && bitPos_q == ACK_SLOT && inhibAct_q) begin
        slaveAct_q <= 1'b0; // RL13
      end
      slvHold_q <= slaveAct_q & eventFlag_q & (~sclIn | slvHold_q); // RL1
      if (!enable) begin
        busy_q <= 1'b0;
      end else if (startDet || startGo) begin // RL23
        busy_q <= 1'b1;
      end else if (stopDet || freeExpire) begin // RL23
        busy_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers and event flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q       <= smbtc_cfg_t'(CFG_RESET);
      startReq_q  <= CTL_RESET[0];
      stopReq_q   <= CTL_RESET[1];
      ackOut_q    <= CTL_RESET[2];
      eventFlag_q <= CTL_RESET[3];
      hwAck_q     <= CTL_RESET[4];
      stopSeen_q  <= CTL_RESET[8];
    end else if (clkEn) begin
      if (wrCfg) begin
        cfg_q <= smbtc_cfg_t'(pwdata[7:0]);
      end
      if (wrCtl) begin
        ackOut_q <= wdCtl.ackOut;
        hwAck_q  <= wdCtl.hwAck;
      end
      if (startEv) begin
        startReq_q <= 1'b0;
      end else if (wrCtl) begin
        startReq_q <= wdCtl.startReq;
      end
      if ((mstSt_q == M_STOP) && (mstSt_d == M_IDLE)) begin
        stopReq_q <= 1'b0;
      end else if (wrCtl) begin
        stopReq_q <= wdCtl.stopReq;
      end
      if (eventSet) begin // RL8
        eventFlag_q <= 1'b1;
      end else if (wrCtl && !wdCtl.eventFlag) begin
        eventFlag_q <= 1'b0;
      end
      if (stopEv) begin
        stopSeen_q <= 1'b1;
      end else if (wrCtl && !wdCtl.eventFlag) begin
        stopSeen_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output flops and APB answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q   <= 32'h0000_0000;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
      sclOe_n_q  <= 1'b1;
      sdaOe_n_q  <= 1'b1;
      t3Reload_q <= 1'b0;
      t3Run_q    <= 1'b0;
    end else if (clkEn) begin
      pready_q   <= apbAcc & ~pready_q;
      pslverr_q  <= apbAcc & ~pready_q & ~hitAny;
      if (apbAcc && !pready_q) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rdMux;
      end
      sclOe_n_q  <= ~(mstScl_q | slvHold_q);
      sdaOe_n_q  <= ~sdaDrv_q;
      t3Reload_q <= cfg_q.sclLowTimeoutEnable & enable & sclIn; // RL3
      t3Run_q    <= cfg_q.sclLowTimeoutEnable & enable & ~sclIn; // RL3
    end
  end

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign sclOut       = 1'b0;
  assign sdaOut       = 1'b0;
  assign sclOe_n      = sclOe_n_q;
  assign sdaOe_n      = sdaOe_n_q;
  assign timer3Reload = t3Reload_q;
  assign timer3Run    = t3Run_q;
  assign eventFlag    = eventFlag_q;
  assign busy         = busy_q;

endmodule

// ### test/smbtc_assertions.sv
`timescale 1ns/1ps
module smbtc_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  // Bus pins and status
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sclOe_n,
  input wire logic sdaOe_n,
  input wire logic timer3Reload,
  input wire logic timer3Run,
  input wire logic eventFlag,
  input wire logic busy
);
  wire logic apbWr = psel && penable && pwrite && pready;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  t3_reload_hi_a: assert property (timer3Reload |-> $past(sclIn))
    else $error("timer reload with scl low");
  t3_run_lo_a: assert property (timer3Run |-> !$past(sclIn))
    else $error("timer run with scl high");
  sda_hold_a: assert property ($fell(sclIn) |=> $stable(sdaOe_n)[*2])
    else $error("sda changed too soon after scl fall");
  sda_setup_a: assert property ($rose(sclOe_n) && !$past(pready, 3) |-> $stable(sdaOe_n))
    else $error("sda changed with scl release");
  scl_low_min_a: assert property ($fell(sclOe_n) |-> !sclOe_n[*3])
    else $error("scl low phase too short");
  scl_high_min_a: assert property ($rose(sclOe_n) |-> sclOe_n[*3])
    else $error("scl high phase too short");
  busy_set_a: assert property ($rose(busy) |-> ##1 !sdaIn)
    else $error("busy set without start");
  busy_clr_a: assert property ($fell(busy) |-> ##[0:2] (sclIn && sdaIn))
    else $error("busy cleared with bus active");
  flag_sw_clr_a: assert property ($fell(eventFlag) |-> $past(apbWr))
    else $error("event flag cleared without write");
  scl_evt_hold_a: assert property ($rose(sclOe_n) && !$past(pready, 3)
    |-> !$past(eventFlag))
    else $error("scl released while event pending");

  cover property ($rose(eventFlag));
  cover property ($fell(busy));
  cover property (timer3Run ##1 timer3Reload);
endmodule

// ### test/smbtc_slave_model.sv
`timescale 1ns/1ps
module smbtc_slave_model (
  // Clock and bus
  input  wire logic       clk,
  input  wire logic       scl,
  input  wire logic       sda,
  // Behaviour
  input  wire logic       ackEn,
  input  wire logic [2:0] stretch,
  input  wire logic [7:0] txByte,
  // Pulls and result
  output logic            sclPull = 1'b0,
  output logic            sdaPull = 1'b0,
  output logic [7:0]      rxByte
);
  logic       sclQ = 1'b1;
  logic       sdaQ = 1'b1;
  logic       rdQ  = 1'b0;
  logic       adrQ = 1'b0;
  logic [3:0] bitQ = 4'hf;
  logic [2:0] strQ = 3'h0;
  logic [7:0] shQ  = 8'h00;
  always @(posedge clk) begin
    if (scl && sclQ && sdaQ && !sda) begin
      bitQ = 4'hf;
      adrQ = 1'b1;
      rdQ  = 1'b0;
    end else if (scl && !sclQ && bitQ < 4'h8) begin
      shQ = {shQ[6:0], sda};
    end else if (!scl && sclQ) begin
      strQ = stretch;
      if (bitQ == 4'h8) begin
        rdQ  = adrQ ? shQ[0] : rdQ;
        adrQ = 1'b0;
      end
      bitQ = (bitQ == 4'h8) ? 4'h0 : bitQ + 4'h1;
      if (bitQ == 4'h8) begin
        rxByte  <= shQ;
        sdaPull <= ackEn && (adrQ || !rdQ);
      end else begin
        sdaPull <= rdQ && !txByte[3'h7 - bitQ[2:0]];
      end
    end else if (strQ != 3'h0) begin
      strQ = strQ - 3'h1;
    end
    sclPull <= strQ != 3'h0;
    sclQ = scl;
    sdaQ = sda;
  end
endmodule

// ### test/tb_smbus_timing_timeout_config.sv
`timescale 1ns/1ps
module tb_smbus_timing_timeout_config
  import smbtc_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, txByte = 8'h00, rxByte;
  logic [31:0] pwdata = 32'h0, prdata, rdQ;
  logic [3:0]  ovf = 4'h0, ovfMask = 4'h0;
  logic [1:0]  tick = 2'h0;
  logic [2:0]  stretch = 3'h0;
  logic        ackEn = 1'b1, pready, pslverr, errQ, t3Reload, t3Run;
  logic        sclOe_n, sdaOe_n, sclPull, sdaPull, eventFlag, busy;
  int          err_count = 0;
  int          samples_checked = 0;
  int          expQ[$];
  wire logic   sclIn = sclOe_n && !sclPull;
  wire logic   sdaIn = sdaOe_n && !sdaPull;

  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    tick <= tick + 2'h1;
    ovf  <= (tick == 2'h3) ? ovfMask : 4'h0;
  end

  smbtc_core dut_u (
    .clk(clk), .rst_n(rst_n), .clkEn(1'b1), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer0Ovf(ovf[0]), .timer1Ovf(ovf[1]),
    .timer2HiOvf(ovf[2]), .timer2LoOvf(ovf[3]), .timer3Reload(t3Reload),
    .timer3Run(t3Run), .sclIn(sclIn), .sclOut(), .sclOe_n(sclOe_n), .sdaIn(sdaIn),
    .sdaOut(), .sdaOe_n(sdaOe_n), .eventFlag(eventFlag), .busy(busy));
  smbtc_slave_model slv_u (.clk(clk), .scl(sclIn), .sda(sdaIn), .ackEn(ackEn),
    .stretch(stretch), .txByte(txByte), .sclPull(sclPull), .sdaPull(sdaPull),
    .rxByte(rxByte));

  task automatic test_done();
    if (err_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdQ  = prdata;
    errQ = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic waitEv();
    @(posedge clk);
    for (int n = 0; n < 2000 && eventFlag !== 1'b1; n++) @(posedge clk);
    repeat (3) @(posedge clk);
    chk(eventFlag, 32'h1);
  endtask

  initial begin
    #(40 * 40000);
    err_count++;
    test_done();
  end

  initial begin
    logic [7:0] a;
    logic [7:0] d;
    logic       hw;
    void'($urandom(45));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, CFG_OFFSET, 32'h0);
    chk(rdQ, {24'h0, CFG_RESET});
    apb(1'b0, 8'h0c, 32'h0);
    chk(errQ, 32'h1);
    chk(rdQ, 32'h0);
    for (int s = 0; s < 4; s++) begin
      ovfMask <= 4'(1 << ((s + 1) % 4));
      apb(1'b1, CFG_OFFSET, 32'h88 | s);
      repeat (2) @(posedge clk);
      chk(t3Reload, 32'h1);
      apb(1'b1, CTL_OFFSET, 32'h1);
      repeat (30) @(posedge clk);
      chk({eventFlag, sclIn}, 32'h1);
      ovfMask <= 4'(1 << s);
      waitEv();
      chk({sclIn, t3Run}, 32'h1);
      apb(1'b1, CFG_OFFSET, 32'h0);
      apb(1'b1, CTL_OFFSET, 32'h0);
    end
    for (int k = 0; k < 4; k++) begin
      a = 8'($urandom);
      d = 8'($urandom) | 8'h80;
      hw = (k == 3);
      ackEn <= (k != 1);
      stretch <= 3'($urandom);
      txByte <= d;
      ovfMask <= 4'h1;
      expQ.push_back({a[7:1], k[1]});
      expQ.push_back(d);
      apb(1'b1, CFG_OFFSET, {27'h0, k[0], 4'h0} | 32'h80);
      apb(1'b1, CTL_OFFSET, {27'h0, hw, 4'h1});
      waitEv();
      apb(1'b1, DAT_OFFSET, {24'h0, a[7:1], k[1]});
      apb(1'b1, CTL_OFFSET, {27'h0, hw, 4'h0});
      waitEv();
      apb(1'b0, CTL_OFFSET, 32'h0);
      chk(rdQ[7:5], {!k[1], 1'b1, ackEn});
      chk(rxByte, expQ.pop_front());
      if (k[1]) begin
        apb(1'b1, CTL_OFFSET, {27'h0, hw, 4'h0});
        waitEv();
        chk(slv_u.bitQ, hw ? 32'h0 : 32'h8);
        apb(1'b0, DAT_OFFSET, 32'h0);
        chk(rdQ, expQ.pop_front());
      end else begin
        apb(1'b1, DAT_OFFSET, {24'h0, d});
        apb(1'b1, CTL_OFFSET, 32'h0);
        waitEv();
        chk(rxByte, expQ.pop_front());
      end
      apb(1'b1, CTL_OFFSET, {27'h0, hw, 4'h2});
      for (int n = 0; n < 500 && busy !== 1'b0; n++) @(posedge clk);
      repeat (2) @(posedge clk);
      chk({sclIn, sdaIn, busy}, 32'h6);
    end
    test_done();
  end
endmodule

bind smbtc_core smbtc_assertions chk_u (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .sclIn(sclIn), .sdaIn(sdaIn),
  .sclOe_n(sclOe_n), .sdaOe_n(sdaOe_n), .timer3Reload(timer3Reload),
  .timer3Run(timer3Run), .eventFlag(eventFlag), .busy(busy));
